// ---- inc/ctm_params.svh ----
// constants of the compact timer: widths, reset values, dividers
`ifndef CTM_PARAMS_SVH
`define CTM_PARAMS_SVH
`define CTM_CNT_W 10
`define CTM_RP_W 3
`define CTM_BYTE_W 8
`define CTM_RP_LSB 7
`define CTM_CNT_RST 10'h000
`define CTM_CMPA_RST 10'h000
`define CTM_BUF_RST 8'h00
`define CTM_SYS_DIV 4
`define CTM_HI_DIV_A 16
`define CTM_HI_DIV_B 64
`define CTM_HI_DIV_W 6
`endif

// ---- inc/ctm_pkg.sv ----
// types shared by the compact timer files
package ctm_pkg;
  // counter clock source codes
  typedef enum logic [2:0] {
    CTM_CK_SYS4 = 3'h0,
    CTM_CK_SYS = 3'h1,
    CTM_CK_HI16 = 3'h2,
    CTM_CK_HI64 = 3'h3,
    CTM_CK_SUB0 = 3'h4,
    CTM_CK_SUB1 = 3'h5,
    CTM_CK_EXT_RISE = 3'h6,
    CTM_CK_EXT_FALL = 3'h7
  } ctm_clk_sel_t;
  // operating modes, code 01 is undefined and behaves as timer
  typedef enum logic [1:0] {
    CTM_MODE_CMP = 2'h0,
    CTM_MODE_UNDEF = 2'h1,
    CTM_MODE_PWM = 2'h2,
    CTM_MODE_TIMER = 2'h3
  } ctm_mode_t;
  // byte registers reachable on the access port
  typedef enum logic [1:0] {
    CTM_SEL_CNT_LO = 2'h0,
    CTM_SEL_CNT_HI = 2'h1,
    CTM_SEL_CMPA_LO = 2'h2,
    CTM_SEL_CMPA_HI = 2'h3
  } ctm_sel_t;
  // loose control bits
  typedef struct packed {
    logic counter_on_bit;
    logic counter_pause_bit;
    ctm_clk_sel_t clock_select_field;
    logic [2:0] period_field;
    ctm_mode_t mode;
    logic [1:0] io_sel;
    logic out_init;
    logic out_polarity;
    logic clear_on_a;
  } ctm_ctrl_t;
  // one byte access request
  typedef struct packed {
    logic req;
    logic we;
    ctm_sel_t sel;
    logic [7:0] wdata;
  } ctm_acc_t;
endpackage

// ---- rtl/ctm_tick_gen.sv ----
// counter clock source selection, dividers and edge detection
`include "ctm_params.svh"
module ctm_tick_gen (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire ctm_pkg::ctm_clk_sel_t clock_select_field,
  input wire logic high_clock_in,
  input wire logic sub_clock_in,
  input wire logic external_count_input,
  output logic count_tick_r
);
  // all state in one struct
  typedef struct packed {
    logic [2:0] s1;        // first sync stage: hi, sub, ext
    logic [2:0] s2;        // second sync stage
    logic [2:0] s3;        // previous value for edge detect
    logic [1:0] sys_div;   // system clock divider
    logic [`CTM_HI_DIV_W-1:0] hi_div; // high clock edge counter
    logic tick;
  } ctm_tick_st_t;
  ctm_tick_st_t st_r;
  ctm_tick_st_t st_nxt;
  logic hi_rise;
  logic sub_rise;
  logic ext_rise;
  logic ext_fall;

  assign count_tick_r = st_r.tick;

  // next state: edges seen only after two sync flops
  always_comb begin
    st_nxt = st_r;
    hi_rise = st_r.s2[2] & ~st_r.s3[2];
    sub_rise = st_r.s2[1] & ~st_r.s3[1];
    ext_rise = st_r.s2[0] & ~st_r.s3[0];
    ext_fall = ~st_r.s2[0] & st_r.s3[0];
    st_nxt.s1 = {high_clock_in, sub_clock_in, external_count_input};
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.sys_div = st_r.sys_div + 2'h1;
    if (hi_rise) begin
      st_nxt.hi_div = st_r.hi_div + `CTM_HI_DIV_W'(1);
    end
    // one-cycle tick from the selected source
    unique case (clock_select_field)
      ctm_pkg::CTM_CK_SYS4: begin
        st_nxt.tick = (st_r.sys_div == 2'(`CTM_SYS_DIV - 1));
      end
      ctm_pkg::CTM_CK_SYS: begin
        st_nxt.tick = 1'b1;
      end
      ctm_pkg::CTM_CK_HI16: begin
        st_nxt.tick = hi_rise &&
          (st_r.hi_div[3:0] == 4'(`CTM_HI_DIV_A - 1));
      end
      ctm_pkg::CTM_CK_HI64: begin
        st_nxt.tick = hi_rise &&
          (st_r.hi_div == `CTM_HI_DIV_W'(`CTM_HI_DIV_B - 1));
      end
      ctm_pkg::CTM_CK_SUB0, ctm_pkg::CTM_CK_SUB1: begin
        st_nxt.tick = sub_rise;
      end
      ctm_pkg::CTM_CK_EXT_RISE: begin
        st_nxt.tick = ext_rise;
      end
      ctm_pkg::CTM_CK_EXT_FALL: begin
        st_nxt.tick = ext_fall;
      end
    endcase
  end

  // register; clock enable freezes everything
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end
endmodule

// ---- rtl/ctm_core.sv ----
// compact timer: 10-bit counter, two comparators, output and byte port
// Functional notes
// - ten-bit up counter advances on selected clock
// - period value compared to counter bits nine-seven
// - compare A value compared to all bits
// - software can only clear counter via on
// - overflow or the selected match clears counter; each match raises its interrupt
// - separate interrupts for comparator A and P
// - clock select picks system, high, sub, external
// - external input counts rising or falling edge
// - inverted output only on instances zero, one
// - compare mode match sets, clears or toggles
// - PWM uses same output and inverted pins
// - low bytes only through eight-bit holding buffer
// - low write buffers; compare A high write commits both
// - high read captures low byte into buffer
// - modes: compare output, timer, PWM
// - on falling holds count; rising clears it
// - period steps of 128; zero means 1024
// - clock select decode per three-bit code
// - pause holds count; release resumes from it
`include "ctm_params.svh"
module ctm_core #(
  parameter bit HAS_INV_OUT = 1'b1, // instances 0 and 1 only
  parameter int CNT_W = `CTM_CNT_W,
  parameter int RP_W = `CTM_RP_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire ctm_pkg::ctm_ctrl_t ctrl,
  input wire ctm_pkg::ctm_acc_t acc,
  input wire logic high_clock_in,
  input wire logic sub_clock_in,
  input wire logic external_count_input,
  output logic [7:0] rdata_r,
  output logic rvalid_r,
  output logic timer_output_pin_r,
  output logic inverted_timer_output_pin_r,
  output logic int_a_r,
  output logic int_p_r,
  output logic [CNT_W-1:0] count_r
);
  // all state of the block
  typedef struct packed {
    logic [CNT_W-1:0] cnt;     // main counter
    logic [CNT_W-1:0] cmpa;    // compare A value
    logic [7:0] hold;          // shared low byte holding buffer
    logic on_prev;             // on bit seen last cycle
    logic level;               // output level before polarity
    logic [7:0] rdata;
    logic rvalid;
    logic int_a;
    logic int_p;
    logic out_pin;
    logic out_inv;
  } ctm_core_st_t;
  ctm_core_st_t st_r;
  ctm_core_st_t st_nxt;
  logic tick;
  logic [CNT_W-1:0] cnt_inc;
  logic [CNT_W-1:0] duty;
  logic [CNT_W-1:0] period_full;
  logic wrap;
  logic match_a;
  logic match_p;
  logic on_rise;
  logic running;
  logic pin;

  // counter clock source, a pulse one cycle wide
  ctm_tick_gen u_tick (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .clock_select_field(ctrl.clock_select_field),
    .high_clock_in(high_clock_in),
    .sub_clock_in(sub_clock_in),
    .external_count_input(external_count_input),
    .count_tick_r(tick)
  );

  // outputs come straight from the state flops
  assign rdata_r = st_r.rdata;
  assign rvalid_r = st_r.rvalid;
  assign timer_output_pin_r = st_r.out_pin;
  assign inverted_timer_output_pin_r = st_r.out_inv;
  assign int_a_r = st_r.int_a;
  assign int_p_r = st_r.int_p;
  assign count_r = st_r.cnt;

  // period as a full count value, zero field gives zero
  function automatic logic [CNT_W-1:0] period_of(input logic [2:0] rp);
    period_of = {rp, {(CNT_W-RP_W){1'b0}}};
  endfunction

  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.int_a = 1'b0;
    st_nxt.int_p = 1'b0;
    st_nxt.rvalid = 1'b0;
    on_rise = ctrl.counter_on_bit & ~st_r.on_prev;
    st_nxt.on_prev = ctrl.counter_on_bit;
    // pause and off both freeze the count in place
    running = ctrl.counter_on_bit & ~ctrl.counter_pause_bit;
    cnt_inc = st_r.cnt + CNT_W'(1);
    wrap = (st_r.cnt == {CNT_W{1'b1}});
    // compare against the value the counter is about to take
    match_a = (cnt_inc == st_r.cmpa);
    period_full = period_of(ctrl.period_field);
    if (ctrl.period_field == '0) begin
      match_p = wrap;
    end else begin
      match_p = (cnt_inc[CNT_W-1:CNT_W-RP_W] == ctrl.period_field) &&
        (cnt_inc[CNT_W-RP_W-1:0] == '0);
    end
    duty = ctrl.clear_on_a ? period_full : st_r.cmpa;

    // counting: clear on rising on, else advance when ticked
    if (on_rise) begin
      st_nxt.cnt = '0;
      st_nxt.level = ctrl.out_init;
    end else if (running && tick) begin
      st_nxt.int_a = match_a;
      st_nxt.int_p = match_p;
      // clear source chosen by the clear select bit
      if ((ctrl.clear_on_a ? match_a : match_p) || wrap) begin
        st_nxt.cnt = '0;
      end else begin
        st_nxt.cnt = cnt_inc;
      end
      // compare output mode reacts to comparator A only
      if (ctrl.mode == ctm_pkg::CTM_MODE_CMP && match_a) begin
        unique case (ctrl.io_sel)
          2'h0: st_nxt.level = st_r.level;
          2'h1: st_nxt.level = 1'b0;
          2'h2: st_nxt.level = 1'b1;
          2'h3: st_nxt.level = ~st_r.level;
        endcase
      end
    end

    // pin level per mode; timer mode leaves the pin as it stands
    unique case (ctrl.mode)
      ctm_pkg::CTM_MODE_CMP: begin
        pin = st_nxt.level ^ ctrl.out_polarity;
      end
      ctm_pkg::CTM_MODE_PWM: begin
        // edge aligned: active from zero until duty is reached
        unique case (ctrl.io_sel)
          2'h1: pin = ctrl.out_init;
          2'h2: pin = (st_nxt.cnt < duty) ? ctrl.out_init
                                           : ~ctrl.out_init;
          default: pin = ~ctrl.out_init;
        endcase
        pin = pin ^ ctrl.out_polarity;
      end
      default: begin
        pin = st_r.out_pin;
      end
    endcase
    st_nxt.out_pin = pin;
    // instance without the inverted pin drives it low
    st_nxt.out_inv = HAS_INV_OUT ? ~pin : 1'b0;

    // byte port; order is software's duty, no checks here
    if (acc.req) begin
      if (acc.we) begin
        unique case (acc.sel)
          ctm_pkg::CTM_SEL_CNT_LO, ctm_pkg::CTM_SEL_CMPA_LO: begin
            st_nxt.hold = acc.wdata;
          end
          ctm_pkg::CTM_SEL_CMPA_HI: begin
            st_nxt.cmpa = {acc.wdata[CNT_W-9:0], st_r.hold};
          end
          ctm_pkg::CTM_SEL_CNT_HI: begin
            st_nxt.hold = st_r.hold; // counter is read only
          end
        endcase
      end else begin
        st_nxt.rvalid = 1'b1;
        unique case (acc.sel)
          ctm_pkg::CTM_SEL_CNT_LO, ctm_pkg::CTM_SEL_CMPA_LO: begin
            st_nxt.rdata = st_r.hold;
          end
          ctm_pkg::CTM_SEL_CNT_HI: begin
            st_nxt.rdata = 8'({st_r.cnt[CNT_W-1:8]});
            st_nxt.hold = st_r.cnt[7:0];
          end
          ctm_pkg::CTM_SEL_CMPA_HI: begin
            st_nxt.rdata = 8'({st_r.cmpa[CNT_W-1:8]});
            st_nxt.hold = st_r.cmpa[7:0];
          end
        endcase
      end
    end
  end

  // register the whole state; clock enable freezes it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.cnt <= `CTM_CNT_RST;
      st_r.cmpa <= `CTM_CMPA_RST;
      st_r.hold <= `CTM_BUF_RST;
      st_r.out_inv <= HAS_INV_OUT;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end
endmodule

// ---- tb/ctm_properties.sv ----
// concurrent checks on the compact timer core ports
module ctm_props #(
  parameter bit HAS_INV_OUT = 1'b1,
  parameter int CNT_W = 10
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire ctm_pkg::ctm_ctrl_t ctrl,
  input wire ctm_pkg::ctm_acc_t acc,
  input wire logic [7:0] rdata_r,
  input wire logic rvalid_r,
  input wire logic timer_output_pin_r,
  input wire logic inverted_timer_output_pin_r,
  input wire logic int_a_r,
  input wire logic int_p_r,
  input wire logic [CNT_W-1:0] count_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // counter byte reads as the port takes them
  sequence s_hi_rd;
    ce && acc.req && !acc.we && acc.sel == ctm_pkg::CTM_SEL_CNT_HI;
  endsequence
  sequence s_lo_rd;
    ce && acc.req && !acc.we && acc.sel == ctm_pkg::CTM_SEL_CNT_LO;
  endsequence
  chk_read_answer: assert property (
    ce && acc.req && !acc.we |=> rvalid_r) else $error("read unanswered");
  chk_hi_byte: assert property (
    s_hi_rd |=> rdata_r == {6'h00, $past(count_r[9:8])})
    else $error("high byte read wrong");
  // the low byte must come from the snapshot, not the live counter
  chk_lo_snapshot: assert property (
    s_hi_rd ##2 s_lo_rd |=> rdata_r == $past(count_r[7:0], 3))
    else $error("low byte not from snapshot");
  chk_count_step: assert property (
    !$stable(count_r) |-> count_r == '0 || count_r == $past(count_r) + 1'b1)
    else $error("counter jumped");
  chk_off_hold: assert property (
    !ctrl.counter_on_bit ##1 !ctrl.counter_on_bit ##1 !ctrl.counter_on_bit
    |-> $stable(count_r)) else $error("counter moved while off");
  chk_pause_hold: assert property (
    ctrl.counter_pause_bit ##1 ctrl.counter_pause_bit |-> $stable(count_r))
    else $error("counter moved while paused");
  chk_on_clear: assert property (
    $rose(ctrl.counter_on_bit) && ce |-> ##[1:2] count_r == '0)
    else $error("counter not cleared on start");
  chk_on_level: assert property (
    $rose(ctrl.counter_on_bit) && ctrl.mode == ctm_pkg::CTM_MODE_CMP
    |-> ##[1:2] timer_output_pin_r == (ctrl.out_init ^ ctrl.out_polarity))
    else $error("output not at initial level");
  chk_a_clear: assert property (
    int_a_r && ctrl.clear_on_a |-> count_r == '0)
    else $error("match did not clear");
  // period match fires as the top bits reach the field, zero meaning wrap
  chk_p_match: assert property (
    $rose(int_p_r) |-> $past(count_r) == {ctrl.period_field, 7'h00} - 10'h001)
    else $error("period match misplaced");
  chk_inv_pin: assert property (
    inverted_timer_output_pin_r ==
    (HAS_INV_OUT ? !timer_output_pin_r : 1'b0)) else $error("inverse wrong");
endmodule

// ---- tb/ctm_core_bench.sv ----
// self-checking bench for the compact timer core
module ctm_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // one row: clock source code and the count window after 256 cycles
  typedef struct packed {
    logic [2:0] src;
    logic [9:0] lo;
    logic [9:0] hi;
  } ctm_row_t;
  ctm_row_t rows [8] = '{'{3'h0, 10'h03E, 10'h040},
    '{3'h1, 10'h0FC, 10'h100}, '{3'h2, 10'h007, 10'h009},
    '{3'h3, 10'h001, 10'h002}, '{3'h4, 10'h01E, 10'h020},
    '{3'h5, 10'h01E, 10'h020}, '{3'h6, 10'h00E, 10'h010},
    '{3'h7, 10'h00E, 10'h010}};
  logic ref_clk = 1'b0, rst = 1'b1, ce = 1'b1; // ce high except during the hold check
  ctm_pkg::ctm_ctrl_t ctrl = '0;
  ctm_pkg::ctm_acc_t acc = '0;
  logic hi_ck = 1'b0, sub_ck = 1'b0, ext_in = 1'b0;
  logic ext_run = 1'b0, ext_man = 1'b0; // external input: free or by hand
  logic [7:0] rdata_r;
  logic rvalid_r, pin, pin_n, int_a_r, int_p_r;
  logic [9:0] count_r;
  int miscompares = 0, checked = 0, cyc = 0;
  ctm_core u_ctm_core (.ref_clk(ref_clk), .rst(rst), .ce(ce), .ctrl(ctrl),
    .acc(acc), .high_clock_in(hi_ck), .sub_clock_in(sub_ck),
    .external_count_input(ext_in), .rdata_r(rdata_r), .rvalid_r(rvalid_r),
    .timer_output_pin_r(pin), .inverted_timer_output_pin_r(pin_n),
    .int_a_r(int_a_r), .int_p_r(int_p_r), .count_r(count_r));
  always #20 ref_clk = ~ref_clk;
  // source clocks at fixed ratios; cycle ceiling cuts a hang short
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    hi_ck <= cyc[0];
    sub_ck <= cyc[2];
    ext_in <= ext_run ? cyc[3] : ext_man;
    if (cyc == 5000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // one byte request held for exactly one taking edge
  task automatic acc_op(input logic we, input ctm_pkg::ctm_sel_t s,
    input logic [7:0] d);
    @(posedge ref_clk) acc <= '{1'b1, we, s, d};
    @(posedge ref_clk) acc.req <= 1'b0;
  endtask
  task automatic rd(input ctm_pkg::ctm_sel_t s, input logic [7:0] e);
    acc_op(1'b0, s, 8'h00);
    @(negedge ref_clk);
    chk("read", {7'h00, rvalid_r, rdata_r}, {8'h01, e});
  endtask
  task automatic tally_and_finish();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    int n;
    tk(12);
    rst <= 1'b0;
    tk(1);
    @(negedge ref_clk);
    chk("reset", {1'b0, count_r, int_a_r, int_p_r, rvalid_r, pin, pin_n},
      {11'h000, 5'h01});
    // a lone low write must stay in the buffer
    acc_op(1'b1, ctm_pkg::CTM_SEL_CMPA_LO, 8'h03);
    acc_op(1'b1, ctm_pkg::CTM_SEL_CMPA_HI, 8'h00);
    acc_op(1'b1, ctm_pkg::CTM_SEL_CMPA_LO, 8'h05);
    rd(ctm_pkg::CTM_SEL_CMPA_HI, 8'h00);
    rd(ctm_pkg::CTM_SEL_CMPA_LO, 8'h03);
    tk(1);
    ctrl.clock_select_field <= ctm_pkg::CTM_CK_SYS;
    ctrl.clear_on_a <= 1'b1;
    ctrl.io_sel <= 2'h3;
    ctrl.counter_on_bit <= 1'b1;
    n = 0;
    repeat (30) begin
      @(negedge ref_clk);
      n += int_a_r;
      chk("below_a", {15'h0000, count_r < 10'h003}, 16'h0001);
    end
    tk(1);
    ctrl.counter_pause_bit <= 1'b1;
    repeat (4) @(negedge ref_clk) n += int_a_r;
    chk("matches", {15'h0000, n >= 9 && n <= 10}, 16'h0001);
    chk("toggle", 16'({pin, pin_n}), 16'({n[0], ~n[0]}));
    tk(1);
    ctrl.counter_pause_bit <= 1'b0;
    // fixed high and low levels reached from the opposite start
    for (int k = 1; k < 3; k++) begin
      ctrl.counter_on_bit <= 1'b0;
      ctrl.io_sel <= 2'(k);
      ctrl.out_init <= k[0];
      tk(2);
      ctrl.counter_on_bit <= 1'b1;
      tk(10);
      @(negedge ref_clk);
      chk("io_level", 16'(pin), 16'(k[1]));
      tk(1);
    end
    ctrl.mode <= ctm_pkg::CTM_MODE_TIMER;
    ctrl.clear_on_a <= 1'b0;
    ext_run <= 1'b1;
    foreach (rows[i]) begin
      ctrl.counter_on_bit <= 1'b0;
      ctrl.clock_select_field <= ctm_pkg::ctm_clk_sel_t'(rows[i].src);
      tk(2);
      ctrl.counter_on_bit <= 1'b1;
      tk(256);
      @(negedge ref_clk);
      chk("rate", {15'h0000, count_r >= rows[i].lo && count_r <= rows[i].hi},
        16'h0001);
      tk(1);
    end
    // edge pwm: period 128 from the field, duty 3 from compare A
    ctrl.counter_on_bit <= 1'b0;
    ctrl.mode <= ctm_pkg::CTM_MODE_PWM;
    ctrl.io_sel <= 2'h2;
    ctrl.out_init <= 1'b1;
    ctrl.period_field <= 3'h1;
    ctrl.clock_select_field <= ctm_pkg::CTM_CK_SYS;
    ext_run <= 1'b0;
    tk(2);
    ctrl.counter_on_bit <= 1'b1;
    tk(20);
    n = 0;
    repeat (128) @(negedge ref_clk) n += pin;
    chk("pwm_duty", 16'(n), 16'h0003);
    // inactive level under inverted polarity, seen on both pins
    tk(1);
    ctrl.io_sel <= 2'h0;
    ctrl.out_polarity <= 1'b1;
    tk(1);
    @(negedge ref_clk);
    chk("pwm_idle", 16'({pin, pin_n}), 16'h0002);
    // clock enable low must freeze a running count
    tk(1);
    ce <= 1'b0;
    tk(1);
    @(negedge ref_clk);
    n = count_r;
    tk(4);
    @(negedge ref_clk);
    chk("ce_hold", 16'(count_r), 16'(n));
    tk(1);
    ce <= 1'b1;
    acc_op(1'b0, ctm_pkg::CTM_SEL_CNT_HI, 8'h00);
    acc_op(1'b0, ctm_pkg::CTM_SEL_CNT_LO, 8'h00);
    ctrl.mode <= ctm_pkg::CTM_MODE_TIMER;
    // one count per chosen edge of the external input
    for (int k = 0; k < 2; k++) begin
      tk(1);
      ctrl.counter_on_bit <= 1'b0;
      ctrl.clock_select_field <= k ? ctm_pkg::CTM_CK_EXT_FALL :
        ctm_pkg::CTM_CK_EXT_RISE;
      tk(2);
      ctrl.counter_on_bit <= 1'b1;
      tk(8);
      ext_man <= 1'b1;
      tk(8);
      @(negedge ref_clk);
      chk("ext_up", 16'(count_r), 16'({9'h000, ~k[0]}));
      tk(1);
      ext_man <= 1'b0;
      tk(8);
      @(negedge ref_clk);
      chk("ext_down", 16'(count_r), 16'h0001);
    end
    tk(1);
    ctrl.counter_on_bit <= 1'b0;
    acc_op(1'b1, ctm_pkg::CTM_SEL_CNT_HI, 8'h03); // refused write
    rd(ctm_pkg::CTM_SEL_CNT_HI, 8'h00);
    rd(ctm_pkg::CTM_SEL_CNT_LO, 8'h01);
    tally_and_finish();
  end
endmodule
bind ctm_core ctm_props #(.HAS_INV_OUT(HAS_INV_OUT), .CNT_W(CNT_W)) u_props (
  .ref_clk(ref_clk), .rst(rst), .ce(ce), .ctrl(ctrl), .acc(acc),
  .rdata_r(rdata_r), .rvalid_r(rvalid_r),
  .timer_output_pin_r(timer_output_pin_r),
  .inverted_timer_output_pin_r(inverted_timer_output_pin_r),
  .int_a_r(int_a_r), .int_p_r(int_p_r), .count_r(count_r));
